// File: bench/dsc_host.sv
/*
  Host processor model that drives the register bank pins.
  Assumes the bench calls its tasks and supplies core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_host (
  // Clock
  input wire logic core_clk,
  // Host bus pins
  output logic host_cs_b,
  output logic host_cd,
  output logic host_ba,
  output logic host_rd_b,
  output logic host_wr_b,
  output logic [7:0] host_din,
  input wire logic [7:0] host_dout
);
  // ****************************************
  // Idle bus
  // ****************************************
  initial begin
    host_cs_b = 1'h1;
    host_cd = 1'h1;
    host_ba = 1'h0;
    host_rd_b = 1'h1;
    host_wr_b = 1'h1;
    host_din = 8'h00;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // One strobe; select and data stay put 4 edges past its end
  task automatic access(input logic ch, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge core_clk);
    host_cs_b <= 1'h0;
    host_ba <= ch;
    host_din <= d;
    @(posedge core_clk);
    // Strobe low long enough for the two sync flops and the answer
    if (w) begin
      host_wr_b <= 1'h0;
    end else begin
      host_rd_b <= 1'h0;
    end
    repeat (6) @(posedge core_clk);
    q = host_dout;
    host_wr_b <= 1'h1;
    host_rd_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    host_cs_b <= 1'h1;
    // Released data lines show the inverse of the last value
    host_din <= ~d;
  endtask

  // Register write: pointer first, unless it is zero
  task automatic wr(input logic ch, input logic [2:0] p, input logic [7:0] d);
    logic [7:0] q;
    if (p != 3'h0) access(ch, 1'h1, {5'h00, p}, q);
    access(ch, 1'h1, d, q);
  endtask

  // Register read: pointer first, unless it is zero
  task automatic rd(input logic ch, input logic [2:0] p, output logic [7:0] q);
    if (p != 3'h0) access(ch, 1'h1, {5'h00, p}, q);
    access(ch, 1'h0, 8'h00, q);
  endtask
endmodule // dsc_host

`default_nettype wire

// File: bench/dsc_regs_test.sv
/*
  Self-checking bench of the serial control register bank.
  Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_regs_test;
  import dsc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic core_clk, rst_b, host_cs_b, host_cd, host_ba, host_rd_b, host_wr_b;
  logic [7:0] host_din, host_dout, vector_out, q, d;
  logic host_dout_oe, int_pending, int_src_ch_a, vectored_mode;
  logic [1:0] tx_char_done, tx_underrun, flag_loaded, int_src_type, int_bus_style;
  logic [1:0] auto_abort, auto_fcs, fcs_preset;
  dsc_line_t [1:0] line_st;
  dsc_cfg_t [1:0] cfg;
  dsc_cmd_t [1:0] cmd, seen_cmd;
  logic [2:0] seen_dp;
  logic seen_oe;
  logic [15:0] len;
  int seed = 32'h5f0a;
  int err_count = 0;
  int check_count = 0;
  int i;

  dsc_regs u_dsc_regs (.core_clk(core_clk), .rst_b(rst_b), .host_cs_b(host_cs_b),
    .host_cd(host_cd), .host_ba(host_ba), .host_rd_b(host_rd_b), .host_wr_b(host_wr_b),
    .host_din(host_din), .host_dout(host_dout), .host_dout_oe(host_dout_oe),
    .line_st(line_st), .tx_char_done(tx_char_done), .tx_underrun(tx_underrun),
    .flag_loaded(flag_loaded), .int_pending(int_pending), .int_src_ch_a(int_src_ch_a),
    .int_src_type(int_src_type), .cfg(cfg), .cmd(cmd), .auto_abort(auto_abort),
    .auto_fcs(auto_fcs), .fcs_preset(fcs_preset), .vectored_mode(vectored_mode),
    .int_bus_style(int_bus_style), .vector_out(vector_out));

  dsc_host u_dsc_host (.core_clk(core_clk), .host_cs_b(host_cs_b), .host_cd(host_cd),
    .host_ba(host_ba), .host_rd_b(host_rd_b), .host_wr_b(host_wr_b),
    .host_din(host_din), .host_dout(host_dout));

  // ****************************************
  // Clock and sticky pulse catchers
  // ****************************************
  initial core_clk = 1'h0;
  always #10 core_clk = ~core_clk;

  // One-cycle strobes are caught here so no edge is missed
  always @(posedge core_clk) begin
    seen_cmd <= seen_cmd | cmd;
    seen_dp <= seen_dp | {auto_abort[0], auto_fcs[0], fcs_preset[0]};
    seen_oe <= seen_oe | host_dout_oe;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Cleared off the edge to avoid racing the catcher
  task automatic clr;
    #1;
    seen_cmd = '0;
    seen_dp = '0;
    seen_oe = 1'b0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [7:0] st0(input logic ch, input dsc_line_t l, input logic ip);
    return {l.brk_abort, l.underrun_eom, l.cts, l.sync_hunt, l.dcd, l.tx_empty, ip & ~ch,
            l.rx_avail};
  endfunction

  function automatic logic [7:0] st1(input dsc_line_t l, input logic hdlc);
    return {l.end_frame & hdlc, l.crc_frm_err, l.overrun, l.parity_err, l.residue, l.all_sent};
  endfunction

  // Source bits land low in the 86 style, in bits 4..2 otherwise
  function automatic logic [7:0] vec(input logic [7:0] b, input logic m, input logic [1:0] s,
                                     input logic [2:0] src);
    if (!m) return b;
    if (s == 2'h2) return {b[7:3], src};
    return {b[7:5], src, b[1:0]};
  endfunction

  // Strobe pattern of a command byte; end of interrupt on the first channel only
  function automatic logic [19:0] ecmd(input logic ch, input logic [7:0] c);
    logic [9:0] e;
    e = (c[5:3] == 3'h0 || (c[5:3] == 3'h7 && ch)) ? 10'h000 : 10'h200 >> (c[5:3] - 3'h1);
    if (c[7:6] != 2'h0) e = 10'h004 >> (c[7:6] - 2'h1);
    return ch ? {e, 10'h000} : {10'h000, e};
  endfunction

  // ****************************************
  // Watchdog and main sequence
  // ****************************************
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    rst_b = 1'h0;
    line_st = '0;
    tx_char_done = 2'h0;
    tx_underrun = 2'h0;
    flag_loaded = 2'h0;
    int_pending = 1'h0;
    int_src_ch_a = 1'h0;
    int_src_type = 2'h0;
    hold(6);
    rst_b <= 1'h1;
    hold(8);
    // Status bytes under random line state; the pointer falls back to zero
    for (i = 0; i < 8; i++) begin
      line_st <= 30'($random(seed));
      int_pending <= 1'($random(seed));
      u_dsc_host.rd(i[0], 3'h0, q);
      check(q, st0(i[0], line_st[i[0]], int_pending));
      u_dsc_host.rd(i[0], 3'h1, q);
      check(q, st1(line_st[i[0]], 1'h0));
      clr();
      u_dsc_host.rd(i[0], 3'h0, q);
      check(q, st0(i[0], line_st[i[0]], int_pending));
      check({seen_oe, host_dout_oe}, 2'h2);
    end
    // Vector place absent on the first channel; write-only places read zero
    u_dsc_host.rd(1'h0, 3'h2, q);
    check(q, 8'h00);
    for (i = 5; i < 8; i++) begin
      u_dsc_host.rd(i[0], i[2:0], q);
      check(q, 8'h00);
    end
    // Every stop, sync and character length code on both channels
    for (i = 0; i < 32; i++) begin
      d = 8'($random(seed));
      d[5:2] = i[4:1];
      u_dsc_host.wr(i[0], 3'h4, d);
      u_dsc_host.wr(i[0], 3'h5, {1'h0, i[2:1], 5'h00});
      hold(3);
      check({cfg[i[0]].sync_mode, cfg[i[0]].stop_bits, cfg[i[0]].par_even, cfg[i[0]].par_en},
            d[5:0]);
      check({cfg[i[0]].is_async, cfg[i[0]].is_hdlc}, {|d[3:2], d[5:2] == 4'h8});
      check(cfg[i[0]].tx_chr_len, i[2:1]);
    end
    // Every command and frame-check code on both channels
    for (i = 0; i < 24; i++) begin
      clr();
      d = (i < 16) ? {2'h0, i[3:1], 3'h0} : {i[2:1], 6'h00};
      u_dsc_host.wr(i[0], 3'h0, d);
      hold(3);
      check(seen_cmd, ecmd(i[0], d));
      if (d[5:3] == 3'h3) check(cfg[i[0]], 11'h000);
    end
    // Vector modes, bus styles, fixed and modified vectors
    for (i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      int_src_ch_a <= 1'($random(seed));
      int_src_type <= 2'($random(seed));
      u_dsc_host.wr(1'h0, 3'h2, {2'h0, i[0], i[2:1], 3'h0});
      u_dsc_host.wr(1'h1, 3'h1, {5'h00, i[3], 2'h0});
      u_dsc_host.wr(1'h1, 3'h2, d);
      hold(3);
      check({vectored_mode, int_bus_style}, {i[0], i[2:1]});
      check(vector_out, vec(d, i[3], i[2:1], {int_src_ch_a, int_src_type}));
      u_dsc_host.rd(1'h1, 3'h2, q);
      check(q, vec(d, i[3], i[2:1], {int_src_ch_a, int_src_type}));
    end
    // Frame mode with length enable: end of frame, counter, underrun, flag
    u_dsc_host.wr(1'h0, 3'h4, 8'h20);
    u_dsc_host.wr(1'h0, 3'h1, 8'h40);
    line_st <= 30'h0000_0001;
    u_dsc_host.rd(1'h0, 3'h1, q);
    check(q, 8'h80);
    for (i = 0; i < 2; i++) begin
      len = i[0] ? 16'h0001 : 16'($random(seed)) | 16'h0002;
      u_dsc_host.wr(1'h0, 3'h6, len[7:0]);
      u_dsc_host.wr(1'h0, 3'h7, len[15:8]);
      tx_char_done <= 2'h1;
      @(posedge core_clk) tx_char_done <= 2'h0;
      len = len - 16'h0001;
      u_dsc_host.rd(1'h0, 3'h3, q);
      check(q, len[7:0]);
      u_dsc_host.rd(1'h0, 3'h4, q);
      check(q, len[15:8]);
      clr();
      @(posedge core_clk) tx_underrun <= 2'h1;
      flag_loaded <= 2'h1;
      @(posedge core_clk) tx_underrun <= 2'h0;
      flag_loaded <= 2'h0;
      hold(3);
      check(seen_dp, {len != 16'h0000, len == 16'h0000, 1'h1});
    end
    end_of_test();
  end
endmodule // dsc_regs_test

`default_nettype wire

// File: common/dsc_consts.svh
/*
  Constants of the dual channel serial control register bank.
  Assumes inclusion by bare name from the register bank and its package users.
*/
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ****************************************
// Pointer values
// ****************************************
`define DSC_PTR_ZERO 3'h0
`define DSC_PTR_VEC 3'h2
`define DSC_PTR_CNT_LO 3'h3
`define DSC_PTR_CNT_HI 3'h4
`define DSC_PTR_SYN_LO 3'h6
`define DSC_PTR_SYN_HI 3'h7

// ****************************************
// Command register fields and codes
// ****************************************
`define DSC_F_PTR 2:0
`define DSC_F_CMD 5:3
`define DSC_F_CRC 7:6
`define DSC_CMD_ABORT 3'h1
`define DSC_CMD_RST_ES 3'h2
`define DSC_CMD_CH_RST 3'h3
`define DSC_CMD_INT_NEXT 3'h4
`define DSC_CMD_RST_TXP 3'h5
`define DSC_CMD_ERR_RST 3'h6
`define DSC_CMD_EOI 3'h7
`define DSC_CRC_INIT_RX 2'h1
`define DSC_CRC_INIT_TX 2'h2
`define DSC_CRC_RST_UND 2'h3

// ****************************************
// Setup register fields
// ****************************************
`define DSC_B_LEN_EN 6
`define DSC_B_MODVEC 2
`define DSC_B_VECTORED 5
`define DSC_F_BUS_STYLE 4:3
`define DSC_F_SYNC 5:4
`define DSC_F_STOP 3:2
`define DSC_B_PAR_EVEN 1
`define DSC_B_PAR_EN 0
`define DSC_F_TX_CHR 6:5
`define DSC_STOP_NONE 2'h0
`define DSC_SYNC_HDLC 2'h2
`define DSC_STYLE_86 2'h2
`define DSC_RST_BYTE 8'h00
`define DSC_RST_CNT 16'h0000
`define DSC_CNT_ONE 16'h0001

`endif

// File: common/dsc_pkg.sv
/*
  Types of the dual channel serial control register bank.
  Assumes the constants header is on the include path.
*/
package dsc_pkg;
  // Line and buffer state from one channel datapath
  typedef struct packed {
    logic brk_abort;
    logic underrun_eom;
    logic cts;
    logic sync_hunt;
    logic dcd;
    logic tx_empty;
    logic rx_avail;
    logic crc_frm_err;
    logic overrun;
    logic parity_err;
    logic [2:0] residue;
    logic all_sent;
    logic end_frame;
  } dsc_line_t;
  // Decoded character format of one channel
  typedef struct packed {
    logic [1:0] stop_bits;
    logic [1:0] sync_mode;
    logic par_even;
    logic par_en;
    logic [1:0] tx_chr_len;
    logic is_async;
    logic is_hdlc;
    logic length_enable;
  } dsc_cfg_t;
  // One cycle command strobes of one channel
  typedef struct packed {
    logic send_abort;
    logic reset_es;
    logic chan_reset;
    logic int_next_rx;
    logic reset_tx_pend;
    logic error_reset;
    logic end_of_int;
    logic crc_init_rx;
    logic crc_init_tx;
    logic reset_underrun;
  } dsc_cmd_t;
endpackage

// File: core/dsc_regs.sv
/*
  Register bank of a two channel multiprotocol serial controller.
  Assumes host pins arrive asynchronously and datapath inputs share core_clk.
*/
// Contract
// - Command pointer selects register; vector only channel two
// - Other registers reached only through written pointer
// - Configuration bit picks vectored or non-vectored
// - Two-bit field selects four bus styles
// - Modified vector substitutes source bits, else base
// - Stop field picks one, one-half, two
// - Parity type bit: clear odd, set even
// - Parity enable adds or omits parity
// - Running length counter readable as two bytes
// - Length enable plus underrun sends abort/FCS; logic does so in HDLC mode only
// - Status top bit shows break detected
// - Interrupt pending bit on first channel only
// - Status bit zero shows receive data waiting
// - Secondary bit zero shows all sent
// - HDLC end of frame in secondary top bit
// - Flag load presets transmit frame check; logic does so in HDLC mode only
`include "dsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dsc_regs
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Host bus pins
  input wire logic host_cs_b,
  input wire logic host_cd,
  input wire logic host_ba,
  input wire logic host_rd_b,
  input wire logic host_wr_b,
  input wire logic [7:0] host_din,
  output logic [7:0] host_dout,
  output logic host_dout_oe,
  // Channel datapath inputs, index 0 first channel
  input wire dsc_line_t [1:0] line_st,
  input wire logic [1:0] tx_char_done,
  input wire logic [1:0] tx_underrun,
  input wire logic [1:0] flag_loaded,
  input wire logic int_pending,
  input wire logic int_src_ch_a,
  input wire logic [1:0] int_src_type,
  // Channel control outputs
  output dsc_cfg_t [1:0] cfg,
  output dsc_cmd_t [1:0] cmd,
  output logic [1:0] auto_abort,
  output logic [1:0] auto_fcs,
  output logic [1:0] fcs_preset,
  // Vector outputs
  output logic vectored_mode,
  output logic [1:0] int_bus_style,
  output logic [7:0] vector_out
);

  // ****************************************
  // Functions
  // ****************************************

  // Character format decode from setup registers
  function automatic dsc_cfg_t cfg_decode(input logic [7:0] r1, input logic [7:0] r4,
                                          input logic [7:0] r5);
    dsc_cfg_t c;
    c.stop_bits = r4[`DSC_F_STOP];
    c.sync_mode = r4[`DSC_F_SYNC];
    c.par_even = r4[`DSC_B_PAR_EVEN];
    c.par_en = r4[`DSC_B_PAR_EN];
    c.tx_chr_len = r5[`DSC_F_TX_CHR];
    c.is_async = (r4[`DSC_F_STOP] != `DSC_STOP_NONE);
    c.is_hdlc = (r4[`DSC_F_STOP] == `DSC_STOP_NONE) &&
                (r4[`DSC_F_SYNC] == `DSC_SYNC_HDLC);
    c.length_enable = r1[`DSC_B_LEN_EN];
    return c;
  endfunction

  // ****************************************
  // Reset and pin synchronisers
  // ****************************************

  logic rst_s1; // Reset release stage one
  logic rst_q; // Released reset, active high when running
  logic [12:0] pin_s1; // First pin stage
  logic [12:0] pin_s2; // Second pin stage, read by logic
  logic rd_prev; // Previous read strobe
  logic wr_prev; // Previous write strobe

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_q <= rst_s1;
    end
  end

  // Pin capture
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      pin_s1 <= 13'h1f00;
      pin_s2 <= 13'h1f00;
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      pin_s1 <= {host_cs_b, host_cd, host_ba, host_rd_b, host_wr_b, host_din};
      pin_s2 <= pin_s1;
      rd_prev <= pin_s2[9];
      wr_prev <= pin_s2[8];
    end
  end

  // ****************************************
  // Host access decode
  // ****************************************

  wire cs_s = !pin_s2[12]; // Chip selected
  wire cd_s = pin_s2[11]; // Control port selected
  wire ch_s = pin_s2[12 - 2]; // Channel select, 1 second channel
  wire rd_s = pin_s2[11 - 2]; // Read strobe level
  wire wr_s = pin_s2[10 - 2]; // Write strobe level
  wire [7:0] din_s = pin_s2[7:0]; // Write data
  wire rd_prev_s = rd_prev;
  wire wr_prev_s = wr_prev;
  // Write taken at the end of the strobe, read at its start
  wire wr_take = cs_s && cd_s && wr_s && !wr_prev_s;
  wire rd_take = cs_s && cd_s && !rd_s && rd_prev_s;
  wire rd_level = cs_s && cd_s && !rd_s;

  // ****************************************
  // Channel registers
  // ****************************************

  logic [2:0] ptr [0:1]; // Register pointer per channel
  logic [7:0] cr [0:1][1:7]; // Setup registers per channel
  logic [7:0] len_lo [0:1]; // Frame length low byte
  logic [15:0] cnt [0:1]; // Running transmit length counter
  logic [7:0] rd_val [0:1]; // Read value per channel
  wire [7:0] vec_now; // Vector as read back or supplied

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      wire sel_w = wr_take && (ch_s == g[0]); // Write to this channel
      wire sel_r = rd_take && (ch_s == g[0]); // Read of this channel
      wire at_cmd = (ptr[g] == `DSC_PTR_ZERO); // Command register reached
      wire [2:0] cmd_code = din_s[`DSC_F_CMD];
      wire [1:0] crc_code = din_s[`DSC_F_CRC];
      wire cmd_w = sel_w && at_cmd;
      wire chan_rst = cmd_w && (cmd_code == `DSC_CMD_CH_RST);
      wire dsc_cfg_t cfg_now = cfg_decode(cr[g][1], cr[g][4], cr[g][5]); // Decoded format
      wire hdlc = cfg_now.is_hdlc;
      wire len_en = cr[g][1][`DSC_B_LEN_EN];
      // Length bytes share the sync pointers while length enable is set
      wire len_lo_w = sel_w && len_en && (ptr[g] == `DSC_PTR_SYN_LO);
      wire len_hi_w = sel_w && len_en && (ptr[g] == `DSC_PTR_SYN_HI);
      dsc_cmd_t next_cmd;

      // Command strobe decode
      always_comb begin
        next_cmd = '0;
        if (cmd_w) begin
          next_cmd.send_abort = (cmd_code == `DSC_CMD_ABORT);
          next_cmd.reset_es = (cmd_code == `DSC_CMD_RST_ES);
          next_cmd.chan_reset = (cmd_code == `DSC_CMD_CH_RST);
          next_cmd.int_next_rx = (cmd_code == `DSC_CMD_INT_NEXT);
          next_cmd.reset_tx_pend = (cmd_code == `DSC_CMD_RST_TXP);
          next_cmd.error_reset = (cmd_code == `DSC_CMD_ERR_RST);
          next_cmd.end_of_int = (cmd_code == `DSC_CMD_EOI) && (g == 0);
          next_cmd.crc_init_rx = (crc_code == `DSC_CRC_INIT_RX);
          next_cmd.crc_init_tx = (crc_code == `DSC_CRC_INIT_TX);
          next_cmd.reset_underrun = (crc_code == `DSC_CRC_RST_UND);
        end
      end

      // Pointer: loaded from command, cleared after indirect access
      always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
          ptr[g] <= `DSC_PTR_ZERO;
        end else if (cmd_w) begin
          ptr[g] <= din_s[`DSC_F_PTR];
        end else if ((sel_w || sel_r) && !at_cmd) begin
          ptr[g] <= `DSC_PTR_ZERO;
        end
      end

      // Setup registers, written only through a pointer
      for (genvar r = 1; r < 8; r = r + 1) begin : gen_cr
        always_ff @(posedge core_clk or negedge rst_q) begin
          if (!rst_q) begin
            cr[g][r] <= `DSC_RST_BYTE;
          end else if (chan_rst) begin
            cr[g][r] <= `DSC_RST_BYTE;
          end else if (sel_w && (ptr[g] == r[2:0]) && !len_lo_w && !len_hi_w) begin
            cr[g][r] <= din_s;
          end
        end
      end

      // Frame length load and running counter
      always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
          len_lo[g] <= `DSC_RST_BYTE;
          cnt[g] <= `DSC_RST_CNT;
        end else begin
          if (len_lo_w) begin
            len_lo[g] <= din_s;
          end
          if (len_hi_w) begin
            cnt[g] <= {din_s, len_lo[g]};
          end else if (tx_char_done[g] && (cnt[g] != `DSC_RST_CNT)) begin
            cnt[g] <= cnt[g] - `DSC_CNT_ONE;
          end
        end
      end

      // Registered channel outputs
      always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
          cmd[g] <= '0;
          cfg[g] <= '0;
          auto_abort[g] <= 1'b0;
          auto_fcs[g] <= 1'b0;
          fcs_preset[g] <= 1'b0;
        end else begin
          cmd[g] <= next_cmd;
          cfg[g] <= cfg_now;
          // Underrun mid-frame aborts, at count end closes with FCS
          auto_abort[g] <= tx_underrun[g] && len_en && hdlc &&
                           (cnt[g] != `DSC_RST_CNT);
          auto_fcs[g] <= tx_underrun[g] && len_en && hdlc &&
                         (cnt[g] == `DSC_RST_CNT);
          fcs_preset[g] <= flag_loaded[g] && hdlc;
        end
      end

      // Status read selection
      wire [7:0] st0 = {line_st[g].brk_abort, line_st[g].underrun_eom,
                        line_st[g].cts, line_st[g].sync_hunt, line_st[g].dcd,
                        line_st[g].tx_empty,
                        (g == 0) ? int_pending : 1'b0,
                        line_st[g].rx_avail};
      wire [7:0] st1 = {line_st[g].end_frame && hdlc,
                        line_st[g].crc_frm_err, line_st[g].overrun,
                        line_st[g].parity_err, line_st[g].residue,
                        line_st[g].all_sent};
      assign rd_val[g] = (ptr[g] == `DSC_PTR_ZERO) ? st0 :
                         (ptr[g] == 3'h1) ? st1 :
                         (ptr[g] == `DSC_PTR_VEC) ? ((g == 1) ? vec_now : `DSC_RST_BYTE) :
                         (ptr[g] == `DSC_PTR_CNT_LO) ? cnt[g][7:0] :
                         (ptr[g] == `DSC_PTR_CNT_HI) ? cnt[g][15:8] :
                         `DSC_RST_BYTE;
    end
  endgenerate

  // ****************************************
  // Vector build
  // ****************************************

  wire [7:0] vec_base = cr[1][2]; // Base vector, second channel
  wire mod_vec = cr[1][1][`DSC_B_MODVEC]; // Modified vector select
  wire [1:0] style = cr[0][2][`DSC_F_BUS_STYLE]; // Bus style
  wire [2:0] src = {int_src_ch_a, int_src_type}; // Source code
  // 86 style places the source in the low bits, 85 styles in bits 4 to 2
  assign vec_now = !mod_vec ? vec_base :
                   (style == `DSC_STYLE_86) ? {vec_base[7:3], src} :
                   {vec_base[7:5], src, vec_base[1:0]};

  // ****************************************
  // Host read port and vector outputs
  // ****************************************

  // Read data latched at read start, driven while read stands
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      host_dout <= `DSC_RST_BYTE;
      host_dout_oe <= 1'b0;
      vectored_mode <= 1'b0;
      int_bus_style <= 2'h0;
      vector_out <= `DSC_RST_BYTE;
    end else begin
      if (rd_take) begin
        host_dout <= rd_val[ch_s];
      end
      host_dout_oe <= rd_level;
      vectored_mode <= cr[0][2][`DSC_B_VECTORED];
      int_bus_style <= style;
      vector_out <= vec_now;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************

  property p_ptr_clear;
    @(posedge core_clk) disable iff (!rst_q)
      (wr_take && !ch_s && ptr[0] != `DSC_PTR_ZERO) |=> (ptr[0] == `DSC_PTR_ZERO);
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

  property p_ptr_load;
    @(posedge core_clk) disable iff (!rst_q)
      (wr_take && ch_s && ptr[1] == `DSC_PTR_ZERO) |=> (ptr[1] == $past(din_s[2:0]));
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_eoi_a_only;
    @(posedge core_clk) disable iff (!rst_q)
      !cmd[1].end_of_int;
  endproperty
  a_eoi_a_only: assert property (p_eoi_a_only) else $error("end of int on second");

  property p_cmd_pulse;
    @(posedge core_clk) disable iff (!rst_q)
      cmd[0].chan_reset |=> !cmd[0].chan_reset;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe held");

  property p_auto_excl;
    @(posedge core_clk) disable iff (!rst_q)
      auto_abort[0] |-> !auto_fcs[0] && $past(tx_underrun[0]) && cfg[0].length_enable;
  endproperty
  a_auto_excl: assert property (p_auto_excl) else $error("bad auto abort");

  property p_preset;
    @(posedge core_clk) disable iff (!rst_q)
      (flag_loaded[0] && gen_ch[0].hdlc) |=> fcs_preset[0];
  endproperty
  a_preset: assert property (p_preset) else $error("frame check not preset");

  property p_vec_plain;
    @(posedge core_clk) disable iff (!rst_q)
      !mod_vec |=> (vector_out == $past(vec_base));
  endproperty
  a_vec_plain: assert property (p_vec_plain) else $error("vector altered");

  property p_cnt_read;
    @(posedge core_clk) disable iff (!rst_q)
      (rd_take && !ch_s && ptr[0] == `DSC_PTR_CNT_HI) |=> (host_dout == $past(cnt[0][15:8]));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("counter high byte wrong");

  property p_sr0_bit0;
    @(posedge core_clk) disable iff (!rst_q)
      (rd_take && !ch_s && ptr[0] == `DSC_PTR_ZERO) |=>
        (host_dout[0] == $past(line_st[0].rx_avail)) &&
        (host_dout[1] == $past(int_pending));
  endproperty
  a_sr0_bit0: assert property (p_sr0_bit0) else $error("status bits wrong");

endmodule // dsc_regs

`default_nettype wire
